/* rtl/ocu_top.sv */
// Output compare unit with AXI4-Lite register slave and compare-driven pin.
// Assumes two timer counts and the fault and idle inputs come from outside
// the clock domain; they are synchronised before use.
//
// Implementation choices: register access over AXI4-Lite and the placing of the registers.
import ocu_pkg::*;

// Behaviour
// RQ1: Enable bit 15 runs the unit; cleared, the unit is inactive.
// RQ2: Idle-stop bit 13 halts the unit while the processor idles.
// RQ3: Wide bit 5 compares 32 bits; otherwise only the lower 16.
// RQ4: Fault flag bit 4 set by hardware on fault; writes ignored.
// RQ5: Fault flag reads zero unless mode is 111.
// RQ6: Timer-select bit 3 picks second timer at one, first at zero.
// RQ7: Mode 111 gives PWM and watches the fault input.
// RQ8: Mode 110 gives PWM and ignores the fault input.
// RQ9: Mode 101 starts low then pulses continuously on compare events.
// RQ10: Mode 100 starts low then produces exactly one pulse.
// RQ11: Mode 011 toggles the pin on every compare match; the code toggles on primary matches only, not on secondary ones.
// RQ12: Mode 010 starts high and drives low on match.
// RQ13: Mode 001 starts low and drives high on match.
// RQ14: Mode 000 does no compare activity on the pin.
// RQ15: Control bits 31-16, 14, 12-6 ignore writes, read zero.
// RQ16: Clear, set, invert aliases sit at control plus 0x4, 0x8, 0xC.
// RQ17: Software avoids register access right after clearing enable.
// RQ18: PWM goes active at period wrap, inactive on secondary match.
// RQ19: Fault in mode 111 forces inactive and latches flag until mode rewrite.
module ocu_top
#(
  parameter int unsigned W = 32
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire ocu_pkg::ocu_axi_req_t axi_req,
  output ocu_pkg::ocu_axi_rsp_t axi_rsp,
  input wire ocu_pkg::ocu_timer_t first_general_timer,
  input wire ocu_pkg::ocu_timer_t second_general_timer,
  input wire logic cpu_idle,
  input wire logic pwm_fault_n,
  output logic compare_output_pin,
  output logic irq
);
  import ocu_pkg::*;

  typedef struct packed {
    ocu_axi_rsp_t rsp;
    logic aw_got;
    logic [ADDR_W-1:0] aw_addr;
    logic w_got;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic [31:0] ctrl;
    logic [W-1:0] pri;
    logic [W-1:0] sec;
    logic [W-1:0] sec_live;
    logic pin;
    logic pulse_done;
    logic fault_hold;
    logic [IRQ_W-1:0] stat;
    logic [IRQ_W-1:0] mask;
    logic irq;
    logic [1:0] idle_sy;
    logic [1:0] flt_sy;
    ocu_timer_t t1a;
    ocu_timer_t t1b;
    ocu_timer_t t2a;
    ocu_timer_t t2b;
  } ocu_st_t;

  ocu_st_t st;
  ocu_st_t next_st;
  logic pri_hit;
  logic sec_hit;
  logic run;
  ocu_timer_t tb;
  ocu_mode_t mode;

  assign mode = ocu_mode_t'(st.ctrl[2:0]);
  // RQ1 RQ2
  assign run = st.ctrl[BIT_ENABLE] && !(st.ctrl[BIT_IDLE_STOP] && st.idle_sy[1]) && (mode != OCU_MODE_OFF);
  assign tb = st.ctrl[BIT_TSEL] ? st.t2b : st.t1b; // RQ6

  ocu_cmp #(
    .W(W)
  ) u_cmp (
    .aclk(aclk),
    .aresetn(aresetn),
    .run(run),
    .wide(st.ctrl[BIT_WIDE]),
    .count(tb.count[W-1:0]),
    .pri_value(st.pri),
    .sec_value(st.sec_live),
    .pri_hit(pri_hit),
    .sec_hit(sec_hit)
  );

  function automatic logic [31:0] rd_mux(input ocu_st_t s, input logic [ADDR_W-1:0] a);
    logic [31:0] v;
    v = 32'h0000_0000;
    case (a)
      OFF_CTRL, OFF_CTRL_CLR, OFF_CTRL_SET, OFF_CTRL_INV: begin
        v = s.ctrl & CTRL_WMASK; // RQ15
        v[BIT_FAULT] = s.fault_hold && (s.ctrl[2:0] == OCU_MODE_PWM_FLT); // RQ5
      end
      OFF_PRI: v = 32'(s.pri);
      OFF_SEC: v = 32'(s.sec);
      OFF_IRQ_STAT: v = 32'(s.stat);
      OFF_IRQ_MASK: v = 32'(s.mask);
      default: v = 32'h0000_0000;
    endcase
    return v;
  endfunction

  function automatic logic known(input logic [ADDR_W-1:0] a);
    return a == OFF_CTRL || a == OFF_CTRL_CLR || a == OFF_CTRL_SET || a == OFF_CTRL_INV ||
           a == OFF_PRI || a == OFF_SEC || a == OFF_IRQ_STAT || a == OFF_IRQ_MASK;
  endfunction

  always_comb begin
    logic [31:0] wm;
    logic [31:0] wv;
    logic [31:0] nc;
    logic mode_wr;
    logic [IRQ_W-1:0] ev;
    logic [IRQ_W-1:0] rd_clr;
    logic flt_now;
    wm = 32'h0000_0000;
    wv = 32'h0000_0000;
    nc = st.ctrl;
    mode_wr = 1'b0;
    ev = '0;
    rd_clr = '0;
    flt_now = 1'b0;
    next_st = st;

    // Pin and timer inputs pass two flip-flops before use
    next_st.idle_sy = {st.idle_sy[0], cpu_idle};
    next_st.flt_sy = {st.flt_sy[0], ~pwm_fault_n};
    next_st.t1a = first_general_timer;
    next_st.t1b = st.t1a;
    next_st.t2a = second_general_timer;
    next_st.t2b = st.t2a;

    // Write channels: address and data may arrive in either order
    next_st.rsp.awready = 1'b0;
    next_st.rsp.wready = 1'b0;
    if (axi_req.awvalid && !st.aw_got && !st.rsp.bvalid) begin
      next_st.rsp.awready = !st.rsp.awready;
      if (st.rsp.awready) begin
        next_st.aw_got = 1'b1;
        next_st.aw_addr = axi_req.awaddr;
      end
    end
    if (axi_req.wvalid && !st.w_got && !st.rsp.bvalid) begin
      next_st.rsp.wready = !st.rsp.wready;
      if (st.rsp.wready) begin
        next_st.w_got = 1'b1;
        next_st.w_data = axi_req.wdata;
        next_st.w_strb = axi_req.wstrb;
      end
    end
    if (st.rsp.bvalid && axi_req.bready) begin
      next_st.rsp.bvalid = 1'b0;
    end
    if (st.aw_got && st.w_got && !st.rsp.bvalid) begin
      next_st.aw_got = 1'b0;
      next_st.w_got = 1'b0;
      next_st.rsp.bvalid = 1'b1;
      next_st.rsp.bresp = known(st.aw_addr) ? RESP_OKAY : RESP_SLVERR;
      for (int i = 0; i < 4; i++) begin
        if (st.w_strb[i]) begin
          wm[i*8 +: 8] = 8'hFF;
        end
      end
      wv = st.w_data & wm;
      // Aliases act on the whole control register with the same byte lanes
      case (st.aw_addr)
        OFF_CTRL: nc = (st.ctrl & ~wm) | wv; // RQ16
        OFF_CTRL_CLR: nc = st.ctrl & ~wv; // RQ16
        OFF_CTRL_SET: nc = st.ctrl | wv; // RQ16
        OFF_CTRL_INV: nc = st.ctrl ^ wv; // RQ16
        OFF_PRI: next_st.pri = W'((32'(st.pri) & ~wm) | wv);
        OFF_SEC: next_st.sec = W'((32'(st.sec) & ~wm) | wv);
        OFF_IRQ_MASK: next_st.mask = (st.mask & ~wm[IRQ_W-1:0]) | wv[IRQ_W-1:0];
        default: nc = st.ctrl;
      endcase
      nc = nc & CTRL_WMASK; // RQ15 RQ4
      mode_wr = (st.aw_addr == OFF_CTRL || st.aw_addr == OFF_CTRL_CLR ||
                 st.aw_addr == OFF_CTRL_SET || st.aw_addr == OFF_CTRL_INV) && wm[0];
      next_st.ctrl = nc;
    end

    // Read channel: one read in flight; data registered one edge after acceptance
    next_st.rsp.arready = 1'b0;
    if (st.rsp.rvalid && axi_req.rready) begin
      next_st.rsp.rvalid = 1'b0;
    end
    if (axi_req.arvalid && !st.rsp.rvalid && !st.rsp.arready) begin
      next_st.rsp.arready = 1'b1;
    end
    if (axi_req.arvalid && st.rsp.arready) begin
      next_st.rsp.rvalid = 1'b1;
      next_st.rsp.rdata = rd_mux(st, axi_req.araddr);
      next_st.rsp.rresp = known(axi_req.araddr) ? RESP_OKAY : RESP_SLVERR;
      if (axi_req.araddr == OFF_IRQ_STAT) begin
        rd_clr = st.stat;
      end
    end

    // Output pin behaviour per mode
    if (mode_wr) begin
      // New mode: set the documented starting level and restart one-shot and fault state
      next_st.pulse_done = 1'b0;
      next_st.fault_hold = 1'b0; // RQ19
      next_st.sec_live = st.sec;
      // Start level only while enabled, so a disabled unit never shows a one-cycle high
      next_st.pin = nc[BIT_ENABLE] && (nc[2:0] == OCU_MODE_FALL); // RQ12 RQ13 RQ9 RQ10
    end else if (!st.ctrl[BIT_ENABLE]) begin
      next_st.pin = 1'b0; // RQ1
    end else if (run) begin
      case (mode)
        OCU_MODE_RISE: if (pri_hit) next_st.pin = 1'b1; // RQ13
        OCU_MODE_FALL: if (pri_hit) next_st.pin = 1'b0; // RQ12
        OCU_MODE_TOGGLE: if (pri_hit) next_st.pin = !st.pin; // RQ11
        OCU_MODE_ONE_PULSE: begin
          // RQ10
          if (pri_hit && !st.pulse_done) begin
            next_st.pin = 1'b1;
          end else if (sec_hit && st.pin) begin
            next_st.pin = 1'b0;
            next_st.pulse_done = 1'b1;
          end
        end
        OCU_MODE_PULSES: begin
          // RQ9
          if (pri_hit) begin
            next_st.pin = 1'b1;
          end else if (sec_hit) begin
            next_st.pin = 1'b0;
          end
        end
        OCU_MODE_PWM, OCU_MODE_PWM_FLT: begin
          flt_now = (mode == OCU_MODE_PWM_FLT) && st.flt_sy[1]; // RQ7 RQ8
          if (flt_now || st.fault_hold) begin
            next_st.fault_hold = 1'b1; // RQ4 RQ19
            next_st.pin = 1'b0; // RQ19
          end else if (tb.period_wrap) begin
            next_st.pin = 1'b1; // RQ18
            next_st.sec_live = st.sec; // RQ18
          end else if (sec_hit) begin
            next_st.pin = 1'b0; // RQ18
          end
        end
        default: next_st.pin = st.pin; // RQ14
      endcase
    end

    ev[IRQ_MATCH_PRI] = run && pri_hit;
    ev[IRQ_MATCH_SEC] = run && sec_hit;
    ev[IRQ_FAULT] = flt_now && !st.fault_hold;
    // A new event wins over the read that clears
    next_st.stat = (st.stat & ~rd_clr) | ev;
    next_st.irq = |(next_st.stat & next_st.mask);
    next_st.rsp.bresp = next_st.rsp.bvalid ? next_st.rsp.bresp : RESP_OKAY;

    if (!aresetn) begin
      next_st = '0;
      next_st.ctrl = CTRL_RESET;
    end
  end

  always_ff @(posedge aclk) begin
    st <= next_st;
  end

  assign axi_rsp = st.rsp;
  assign compare_output_pin = st.pin;
  assign irq = st.irq;
endmodule

/* rtl/ocu_pkg.sv */
// Package for the output compare unit: register map, control fields, modes.
// Assumes a 32-bit AXI4-Lite register bus and one 50 MHz clock.
package ocu_pkg;
  localparam int unsigned ADDR_W = 8;
  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFF_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_CTRL_CLR = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_CTRL_SET = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_CTRL_INV = 8'h0C;
  localparam logic [ADDR_W-1:0] OFF_PRI = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_SEC = 8'h20;
  localparam logic [ADDR_W-1:0] OFF_IRQ_STAT = 8'h30;
  localparam logic [ADDR_W-1:0] OFF_IRQ_MASK = 8'h34;
  // Control field positions
  localparam int unsigned BIT_ENABLE = 15;
  localparam int unsigned BIT_IDLE_STOP = 13;
  localparam int unsigned BIT_WIDE = 5;
  localparam int unsigned BIT_FAULT = 4;
  localparam int unsigned BIT_TSEL = 3;
  localparam logic [31:0] CTRL_WMASK = 32'h0000_A02F;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  // Interrupt status bits
  localparam int unsigned IRQ_MATCH_PRI = 0;
  localparam int unsigned IRQ_MATCH_SEC = 1;
  localparam int unsigned IRQ_FAULT = 2;
  localparam int unsigned IRQ_W = 3;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [2:0] {
    OCU_MODE_OFF = 3'b000,
    OCU_MODE_RISE = 3'b001,
    OCU_MODE_FALL = 3'b010,
    OCU_MODE_TOGGLE = 3'b011,
    OCU_MODE_ONE_PULSE = 3'b100,
    OCU_MODE_PULSES = 3'b101,
    OCU_MODE_PWM = 3'b110,
    OCU_MODE_PWM_FLT = 3'b111
  } ocu_mode_t;

  typedef struct packed {
    logic awvalid;
    logic [ADDR_W-1:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [ADDR_W-1:0] araddr;
    logic rready;
  } ocu_axi_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } ocu_axi_rsp_t;

  typedef struct packed {
    logic [31:0] count;
    logic period_wrap;
  } ocu_timer_t;
endpackage

/* rtl/ocu_cmp.sv */
// Compare engine: matches a timer count against the two compare values.
// Assumes the count and values are stable in the clock domain of the caller.
module ocu_cmp
  import ocu_pkg::*;
#(
  parameter int unsigned W = 32
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic run,
  input wire logic wide,
  input wire logic [W-1:0] count,
  input wire logic [W-1:0] pri_value,
  input wire logic [W-1:0] sec_value,
  output logic pri_hit,
  output logic sec_hit
);
  typedef struct packed {
    logic pri_hit;
    logic sec_hit;
    logic [W-1:0] last;
  } ocu_cmp_st_t;

  ocu_cmp_st_t st;
  ocu_cmp_st_t next_st;
  logic [W-1:0] mask;

  always_comb begin
    mask = wide ? '1 : {{(W-16){1'b0}}, 16'hFFFF}; // RQ3
    next_st = st;
    next_st.last = count & mask;
    // A hit fires once when the count first arrives at the value, not while it sits there
    next_st.pri_hit = run && ((count & mask) == (pri_value & mask)) && ((count & mask) != st.last);
    next_st.sec_hit = run && ((count & mask) == (sec_value & mask)) && ((count & mask) != st.last);
    if (!aresetn) begin
      next_st = '0;
    end
  end

  always_ff @(posedge aclk) begin
    st <= next_st;
  end

  assign pri_hit = st.pri_hit;
  assign sec_hit = st.sec_hit;
endmodule

/* dv/ocu_asserts.sv */
// Checker for ocu_top: register bus answers and control read-back.
// Assumes an AXI4-Lite master that holds each request until it is taken.
module ocu_asserts
#(parameter int unsigned W = 32) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire ocu_pkg::ocu_axi_req_t axi_req,
  input wire ocu_pkg::ocu_axi_rsp_t axi_rsp,
  input wire ocu_pkg::ocu_timer_t first_general_timer,
  input wire ocu_pkg::ocu_timer_t second_general_timer,
  input wire logic cpu_idle,
  input wire logic pwm_fault_n,
  input wire logic compare_output_pin,
  input wire logic irq
);
  timeunit 1ns;
  timeprecision 1ns;
  import ocu_pkg::*;
  logic [ADDR_W-1:0] ra;
  logic hit;
  logic rc;
  // Read address is kept because the master drops araddr once taken
  always_ff @(posedge aclk) if (axi_req.arvalid && axi_rsp.arready) ra <= axi_req.araddr;
  assign hit = ra inside {OFF_CTRL, OFF_CTRL_CLR, OFF_CTRL_SET, OFF_CTRL_INV, OFF_PRI, OFF_SEC, OFF_IRQ_STAT,
    OFF_IRQ_MASK};
  assign rc = axi_rsp.rvalid && ra == OFF_CTRL;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_bresp_holds: assert property (axi_rsp.bvalid && !axi_req.bready |=> axi_rsp.bvalid && $stable(axi_rsp.bresp))
    else $error("write response dropped early");
  a_rdata_holds: assert property (axi_rsp.rvalid && !axi_req.rready |=> axi_rsp.rvalid && $stable(axi_rsp.rdata))
    else $error("read data dropped early");
  a_read_follows: assert property (axi_req.arvalid && axi_rsp.arready |=> axi_rsp.rvalid)
    else $error("read answer late");
  a_map_okay: assert property (axi_rsp.rvalid && hit |-> axi_rsp.rresp == RESP_OKAY)
    else $error("mapped read refused");
  a_unmapped_err: assert property (axi_rsp.rvalid && !hit |-> axi_rsp.rresp == RESP_SLVERR && axi_rsp.rdata == 0)
    else $error("unmapped read accepted");
  a_ctrl_zero_bits: assert property (rc |-> (axi_rsp.rdata & ~CTRL_WMASK & ~32'h0000_0010) == 32'h0)
    else $error("unimplemented control bit set");
  a_fault_mode: assert property (rc && axi_rsp.rdata[2:0] != 3'b111 |-> !axi_rsp.rdata[BIT_FAULT])
    else $error("fault flag outside mode 111");
  a_off_low: assert property (rc && !axi_rsp.rdata[BIT_ENABLE] |-> !compare_output_pin)
    else $error("pin high while disabled");
  c_write: cover property (axi_rsp.bvalid && axi_req.bready);
  c_pin_rise: cover property ($rose(compare_output_pin));
  c_irq: cover property ($rose(irq));
endmodule
bind ocu_top ocu_asserts #(.W(W)) i_ocu_asserts (.aclk(aclk), .aresetn(aresetn), .axi_req(axi_req),
  .axi_rsp(axi_rsp), .first_general_timer(first_general_timer), .second_general_timer(second_general_timer),
  .cpu_idle(cpu_idle), .pwm_fault_n(pwm_fault_n), .compare_output_pin(compare_output_pin), .irq(irq));

/* dv/ocu_load_model.sv */
// Load on the compare pin: counts the rising edges it sees.
// Assumes the pin is sampled on the block's own clock.
module ocu_load_model (
  input wire logic aclk,
  input wire logic compare_output_pin,
  output logic [7:0] rises
);
  timeunit 1ns;
  timeprecision 1ns;
  logic last;
  initial begin
    rises = 8'h00;
    last = 1'b0;
  end
  always @(posedge aclk) begin
    if (compare_output_pin && !last) rises <= rises + 8'h01;
    last <= compare_output_pin;
  end
endmodule

/* dv/ocu_tb_top.sv */
// Testbench for ocu_top: register tests and pin behaviour per mode.
// Assumes a free 256-count first timer; the second runs 128 counts ahead.
module ocu_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import ocu_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  ocu_axi_req_t req = '0;
  ocu_axi_rsp_t rsp;
  ocu_timer_t t1 = '0;
  ocu_timer_t t2 = '0;
  logic cpu_idle = 1'b0;
  logic fault_n = 1'b1;
  logic pin;
  logic irq;
  logic [7:0] rises;
  logic [7:0] r0;
  logic [31:0] rd;
  logic [1:0] rr;
  int num_errors = 0;
  int checked = 0;
  always #10 aclk = ~aclk;
  always @(posedge aclk) begin
    t1.count <= (t1.count == 32'h0000_00FF) ? 32'h0 : t1.count + 32'h1;
    t1.period_wrap <= (t1.count == 32'h0000_00FE);
    t2.count <= (t1.count + 32'h81) & 32'hFF;
  end
  ocu_top #(.W(32)) i_ocu_top (.aclk(aclk), .aresetn(aresetn), .axi_req(req), .axi_rsp(rsp),
    .first_general_timer(t1), .second_general_timer(t2), .cpu_idle(cpu_idle), .pwm_fault_n(fault_n),
    .compare_output_pin(pin), .irq(irq));
  ocu_load_model i_ocu_load_model (.aclk(aclk), .compare_output_pin(pin), .rises(rises));
  task automatic summarize;
    $display("errors %0d checks %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      num_errors++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw;
    logic w;
    aw = 1'b0;
    w = 1'b0;
    @(posedge aclk);
    req.awvalid <= 1'b1;
    req.awaddr <= a;
    req.wvalid <= 1'b1;
    req.wdata <= d;
    req.wstrb <= 4'hF;
    // bvalid is looked for only after both halves were taken
    while (!(aw && w)) begin
      @(posedge aclk);
      if (rsp.awready) begin
        aw = 1;
        req.awvalid <= 1'b0;
      end
      if (rsp.wready) begin
        w = 1;
        req.wvalid <= 1'b0;
      end
    end
    do begin
      @(posedge aclk);
    end while (!rsp.bvalid);
    // Ready follows the answer by one edge, so the slave must keep it standing
    req.bready <= 1'b1;
    @(posedge aclk);
    rr = rsp.bresp;
    req.bready <= 1'b0;
  endtask
  task automatic rdr(input logic [7:0] a);
    @(posedge aclk);
    req.arvalid <= 1'b1;
    req.araddr <= a;
    do begin
      @(posedge aclk);
      if (rsp.arready) req.arvalid <= 1'b0;
    end while (!rsp.rvalid);
    req.rready <= 1'b1;
    @(posedge aclk);
    rd = rsp.rdata;
    rr = rsp.rresp;
    req.rready <= 1'b0;
  endtask
  task automatic at(input logic [31:0] v);
    int n;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
    end while (t1.count !== v && n < 600);
    if (t1.count !== v) chk("count", v, t1.count);
  endtask
  // Mode writes land early in a period, well before the count reaches 50
  task automatic md(input logic [31:0] c);
    at(32'hA);
    wr(OFF_CTRL, c);
  endtask
  task automatic pa(input logic [31:0] v, input logic e);
    at(v);
    chk("pin", {31'h0, e}, {31'h0, pin});
  endtask
  task automatic rc(input logic [31:0] e);
    rdr(OFF_CTRL);
    chk("ctrl", e, rd);
  endtask
  initial begin
    #1000000;
    chk("watchdog", 32'h1, 32'h0);
    summarize;
  end
  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    rc(32'h0);
    wr(OFF_CTRL, 32'hFFFF_FFFF);
    rc(32'h0000_A02F);
    wr(OFF_CTRL_CLR, 32'hFFFF_FFFF);
    rc(32'h0);
    wr(OFF_CTRL_SET, 32'h0000_8001);
    rc(32'h0000_8001);
    wr(OFF_CTRL_INV, 32'h0000_0003);
    rc(32'h0000_8002);
    rdr(8'h40);
    chk("rresp", {30'h0, RESP_SLVERR}, {30'h0, rr});
    chk("rdata", 32'h0, rd);
    wr(8'h40, 32'h0000_8001);
    chk("bresp", {30'h0, RESP_SLVERR}, {30'h0, rr});
    rc(32'h0000_8002);
    wr(OFF_PRI, 32'h32);
    wr(OFF_SEC, 32'h96);
    md(32'h8001);
    pa(32'd40, 0);
    pa(32'd100, 1);
    md(32'h8002);
    pa(32'd40, 1);
    pa(32'd100, 0);
    cpu_idle <= 1'b1;
    md(32'h8003);
    pa(32'd100, 1);
    pa(32'd100, 0);
    md(32'h0000_A003);
    pa(32'd100, 0);
    cpu_idle <= 1'b0;
    pa(32'd100, 1);
    md(32'h8004);
    r0 = rises;
    pa(32'd100, 1);
    pa(32'd200, 0);
    pa(32'd100, 0);
    chk("rises", 32'h1, {24'h0, rises - r0});
    md(32'h8005);
    r0 = rises;
    pa(32'd40, 0);
    pa(32'd100, 1);
    pa(32'd200, 0);
    pa(32'd100, 1);
    chk("rises", 32'h2, {24'h0, rises - r0});
    fault_n <= 1'b0;
    md(32'h8006);
    pa(32'd200, 0);
    pa(32'd100, 1);
    pa(32'd200, 0);
    md(32'h8007);
    pa(32'd100, 0);
    rc(32'h0000_8017);
    fault_n <= 1'b1;
    pa(32'd100, 0);
    rc(32'h0000_8017);
    md(32'h8006);
    rc(32'h0000_8006);
    md(32'h8000);
    pa(32'd100, 0);
    md(32'h0001);
    pa(32'd100, 0);
    md(32'h8009);
    pa(32'd100, 0);
    pa(32'd200, 1);
    wr(OFF_PRI, 32'h0001_0032);
    md(32'h8001);
    pa(32'd100, 1);
    md(32'h8021);
    pa(32'd200, 0);
    wr(OFF_PRI, 32'h32);
    md(32'h8001);
    wr(OFF_IRQ_MASK, 32'h1);
    rdr(OFF_IRQ_STAT);
    at(32'd100);
    chk("irq", 32'h1, {31'h0, irq});
    rdr(OFF_IRQ_STAT);
    chk("status", 32'h1, rd);
    at(32'd120);
    chk("irq", 32'h0, {31'h0, irq});
    rdr(OFF_IRQ_STAT);
    chk("status", 32'h0, rd);
    wr(OFF_IRQ_MASK, 32'h0);
    at(32'd100);
    chk("irq", 32'h0, {31'h0, irq});
    summarize;
  end
endmodule
